// >>> ccd_pkg.sv
// Package for the group-three channel divider control block.
// Assumes one 8-bit register write/read port with 10-bit addresses.
package ccd_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [9:0] CCD_OFS_COUNTS = 10'h199; // High/low counts
   localparam logic [9:0] CCD_OFS_CTRL = 10'h19a; // Divider control
   localparam logic [9:0] CCD_OFS_ROUTE = 10'h19b; // Routing and power
   localparam logic [9:0] CCD_OFS_PRESC = 10'h1e0; // Prescale ratio code
   localparam logic [9:0] CCD_OFS_SRC = 10'h1e1; // Source select/bypass

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CCD_BIT_BYPASS = 7;
   localparam int CCD_BIT_IGNORE = 6;
   localparam int CCD_BIT_FORCE = 5;
   localparam int CCD_BIT_START = 4;
   localparam int CCD_BIT_PD = 2;
   localparam int CCD_BIT_DIRECT = 1;
   localparam int CCD_BIT_DCC_DIS = 0;
   localparam int CCD_BIT_SRC_SEL = 1;
   localparam int CCD_BIT_PRE_BYP = 0;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] CCD_RST_COUNTS = 8'h00;
   localparam logic [7:0] CCD_RST_CTRL = 8'h00;
   localparam logic [2:0] CCD_RST_ROUTE = 3'h0;
   localparam logic [2:0] CCD_RST_PRESC = 3'h0;
   localparam logic [1:0] CCD_RST_SRC = 2'h0;

   // Source field codes that matter for direct routing
   localparam logic [1:0] CCD_SRC_OSC_DIRECT = 2'h2;
   localparam logic [1:0] CCD_SRC_EXT_DIRECT = 2'h0;

   // Channel divider control fields
   typedef struct packed {
      logic bypass;
      logic ignore_align;
      logic force_static;
      logic start_high;
      logic [3:0] phase;
   } ccd_ctrl_t;

   // Divider sequencing states
   typedef enum logic [0:0] {
      CCD_ST_RUN = 1'b0,
      CCD_ST_DELAY = 1'b1
   } ccd_state_t;
endpackage

// >>> ccd_channel_ctrl.sv
// Group-three channel divider, prescale divider and output routing.
// Assumes oscillator and external clock arrive as levels synchronous
// to ref_clk_i, each toggling no faster than every second cycle.
`timescale 1ns/10ps
`default_nettype none
module ccd_channel_ctrl (
   input wire logic ref_clk_i, // 50 MHz system clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic wr_en_i, // Register write strobe
   input wire logic [9:0] addr_i, // Register address
   input wire logic [7:0] wdata_i, // Register write data
   output logic [7:0] rdata_o, // Read data, one cycle after addr
   input wire logic internal_oscillator_i, // Oscillator level
   input wire logic ext_clk_i, // External clock level
   input wire logic align_i, // Chip-level alignment pulse
   output logic group_output_a_o, // Group output A
   output logic group_output_b_o, // Group output B
   output logic group_output_c_o, // Group output C
   output logic group_pd_o, // Group drivers powered down
   output logic duty_cycle_correction_en_o // Duty correction enable
);
   import ccd_pkg::*;

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [7:0] counts_q, counts_d; // [7:4] low, [3:0] high
   ccd_ctrl_t ctrl_q, ctrl_d; // Divider control
   logic [2:0] route_q, route_d; // Power-down, direct, dcc disable
   logic [2:0] presc_q, presc_d; // Prescale code
   logic [1:0] src_q, src_d; // Source select, prescale bypass
   logic [7:0] rdata_q, rdata_d; // Registered read data

   // Write decode and read mux
   always_comb begin
      counts_d = counts_q;
      ctrl_d = ctrl_q;
      route_d = route_q;
      presc_d = presc_q;
      src_d = src_q;
      if (wr_en_i) begin
         case (addr_i)
            CCD_OFS_COUNTS: counts_d = wdata_i;
            CCD_OFS_CTRL: ctrl_d = wdata_i;
            CCD_OFS_ROUTE: route_d = wdata_i[2:0];
            CCD_OFS_PRESC: presc_d = wdata_i[2:0];
            CCD_OFS_SRC: src_d = wdata_i[1:0];
            default: ;
         endcase
      end
      // Unused bits and unmapped addresses read as zero
      case (addr_i)
         CCD_OFS_COUNTS: rdata_d = counts_q;
         CCD_OFS_CTRL: rdata_d = ctrl_q;
         CCD_OFS_ROUTE: rdata_d = {5'h00, route_q};
         CCD_OFS_PRESC: rdata_d = {5'h00, presc_q};
         CCD_OFS_SRC: rdata_d = {6'h00, src_q};
         default: rdata_d = 8'h00;
      endcase
   end

   // Register update
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         counts_q <= CCD_RST_COUNTS;
         ctrl_q <= CCD_RST_CTRL;
         route_q <= CCD_RST_ROUTE;
         presc_q <= CCD_RST_PRESC;
         src_q <= CCD_RST_SRC;
         rdata_q <= 8'h00;
      end else begin
         counts_q <= counts_d;
         ctrl_q <= ctrl_d;
         route_q <= route_d;
         presc_q <= presc_d;
         src_q <= src_d;
         rdata_q <= rdata_d;
      end
   end

   assign rdata_o = rdata_q;

   // ------------------------------------------------------------
   // Prescale divider
   // ------------------------------------------------------------
   logic src_lvl; // Selected source level
   logic src_prev_q; // Source level last cycle
   logic src_rise; // Source rising edge
   logic [2:0] ratio; // Divide ratio from code
   logic [2:0] pcnt_q, pcnt_d; // Prescale edge count
   logic plvl_q, plvl_d; // Prescaled level
   logic div_in; // Channel divider input level

   // Source choice and ratio decode
   always_comb begin
      src_lvl = src_q[CCD_BIT_SRC_SEL] ? internal_oscillator_i
                                       : ext_clk_i;
      case (presc_q)
         3'h0: ratio = 3'h2;
         3'h1: ratio = 3'h3;
         3'h2: ratio = 3'h4;
         3'h3: ratio = 3'h5;
         3'h4: ratio = 3'h6;
         default: ratio = 3'h2; // Undefined codes fall back to two
      endcase
      src_rise = src_lvl & ~src_prev_q;
      pcnt_d = pcnt_q;
      plvl_d = plvl_q;
      if (src_rise) begin
         // Wrap at ratio; high for the first ratio>>1 counts of each period
         pcnt_d = (pcnt_q >= ratio - 3'h1) ? 3'h0 : pcnt_q + 3'h1;
         plvl_d = (pcnt_d < (ratio >> 1));
      end
      div_in = src_q[CCD_BIT_PRE_BYP] ? src_lvl : plvl_q;
   end

   // Prescale state
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         src_prev_q <= 1'b0;
         pcnt_q <= 3'h0;
         plvl_q <= 1'b0;
      end else begin
         src_prev_q <= src_lvl;
         pcnt_q <= pcnt_d;
         plvl_q <= plvl_d;
      end
   end

   // ------------------------------------------------------------
   // Channel divider
   // ------------------------------------------------------------
   ccd_state_t st_q, st_d; // Delay or run
   logic in_prev_q; // Divider input last cycle
   logic in_rise; // Divider input rising edge
   logic [3:0] dly_q, dly_d; // Remaining phase-offset edges
   logic [3:0] hcnt_q, hcnt_d; // Edges spent in current phase
   logic lvl_q, lvl_d; // Divided level
   logic [3:0] limit; // Count for current phase
   logic align_ok; // Alignment pulse obeyed

   // Divider sequencing; align takes precedence over counting
   always_comb begin
      in_rise = div_in & ~in_prev_q;
      align_ok = align_i & ~ctrl_q.ignore_align;
      limit = lvl_q ? counts_q[3:0] : counts_q[7:4];
      st_d = st_q;
      dly_d = dly_q;
      hcnt_d = hcnt_q;
      lvl_d = lvl_q;
      if (align_ok) begin
         // Restart aligned from start level and offset
         lvl_d = ctrl_q.start_high;
         hcnt_d = 4'h0;
         dly_d = ctrl_q.phase;
         st_d = (ctrl_q.phase != 4'h0) ? CCD_ST_DELAY : CCD_ST_RUN;
      end else if (in_rise) begin
         case (st_q)
            CCD_ST_DELAY: begin
               // Hold start level while offset runs out
               dly_d = dly_q - 4'h1;
               if (dly_q == 4'h1) begin
                  st_d = CCD_ST_RUN;
               end
            end
            CCD_ST_RUN: begin
               // Phase ends after limit plus one edges
               if (hcnt_q >= limit) begin
                  hcnt_d = 4'h0;
                  lvl_d = ~lvl_q;
               end else begin
                  hcnt_d = hcnt_q + 4'h1;
               end
            end
            default: st_d = CCD_ST_RUN;
         endcase
      end
   end

   // Divider state
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= CCD_ST_RUN;
         in_prev_q <= 1'b0;
         dly_q <= 4'h0;
         hcnt_q <= 4'h0;
         lvl_q <= 1'b0;
      end else begin
         st_q <= st_d;
         in_prev_q <= div_in;
         dly_q <= dly_d;
         hcnt_q <= hcnt_d;
         lvl_q <= lvl_d;
      end
   end

   // ------------------------------------------------------------
   // Output routing
   // ------------------------------------------------------------
   logic out_q, out_d; // Shared group output level
   logic pd; // Group power-down
   logic direct; // Direct-to-output request

   // Priority: power-down, direct routing, bypass, force, divider
   always_comb begin
      pd = route_q[CCD_BIT_PD];
      direct = route_q[CCD_BIT_DIRECT];
      if (pd) begin
         out_d = 1'b0; // Safe state
      end else if (direct && src_q == CCD_SRC_OSC_DIRECT) begin
         out_d = internal_oscillator_i;
      end else if (direct && src_q == CCD_SRC_EXT_DIRECT) begin
         out_d = ext_clk_i;
      end else if (ctrl_q.bypass) begin
         // Bypass wins over force; field 01b lands here too
         out_d = div_in;
      end else if (ctrl_q.ignore_align && ctrl_q.force_static) begin
         out_d = ctrl_q.start_high; // Static level
      end else begin
         out_d = lvl_q;
      end
   end

   // Output register; one flop feeds all three drivers for zero skew
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_q <= 1'b0;
      end else begin
         out_q <= out_d;
      end
   end

   assign group_output_a_o = out_q;
   assign group_output_b_o = out_q;
   assign group_output_c_o = out_q;
   assign group_pd_o = pd;
   assign duty_cycle_correction_en_o = ~route_q[CCD_BIT_DCC_DIS];

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_pd_safe_low: assert property (pd |=> !out_q)
      else $error("output not low while powered down");
   a_bypass_pass: assert property (
      !pd && !direct && ctrl_q.bypass |=> out_q == $past(div_in))
      else $error("bypass did not pass divider input");
   a_bypass_beats_force: assert property (
      !pd && !direct && ctrl_q.bypass && ctrl_q.force_static
      && ctrl_q.ignore_align |=> out_q == $past(div_in))
      else $error("force acted while bypassed");
   a_force_static: assert property (
      !pd && !direct && !ctrl_q.bypass && ctrl_q.ignore_align
      && ctrl_q.force_static |=> out_q == $past(ctrl_q.start_high))
      else $error("forced output not at start level");
   a_force_needs_ignore: assert property (
      !pd && !direct && !ctrl_q.bypass && !ctrl_q.ignore_align
      |=> out_q == $past(lvl_q))
      else $error("force acted without ignore");
   a_align_restart: assert property (
      align_i && !ctrl_q.ignore_align |=> lvl_q == $past(ctrl_q.start_high)
      && dly_q == $past(ctrl_q.phase))
      else $error("alignment did not restart divider");
   a_align_ignored: assert property (
      align_i && ctrl_q.ignore_align && !in_rise
      |=> $stable(lvl_q) && $stable(dly_q))
      else $error("ignored alignment changed divider");
   a_direct_osc: assert property (
      !pd && direct && src_q == CCD_SRC_OSC_DIRECT
      |=> out_q == $past(internal_oscillator_i))
      else $error("oscillator not routed directly");
   a_direct_ext: assert property (
      !pd && direct && src_q == CCD_SRC_EXT_DIRECT
      |=> out_q == $past(ext_clk_i))
      else $error("external clock not routed directly");
   a_direct_noeffect: assert property (
      !pd && direct && src_q == 2'h1 && !ctrl_q.bypass
      && !ctrl_q.ignore_align |=> out_q == $past(lvl_q))
      else $error("direct bit acted with field 01b");
   a_dcc_write: assert property (
      wr_en_i && addr_i == CCD_OFS_ROUTE
      |=> duty_cycle_correction_en_o == !$past(wdata_i[0]))
      else $error("duty correction enable wrong");
   a_presc_wrap: assert property (
      src_rise && pcnt_q == ratio - 3'h1 |=> pcnt_q == 3'h0)
      else $error("prescale count did not wrap");
   a_presc_ratio6: assert property (
      presc_q == 3'h4 |-> ratio == 3'h6)
      else $error("code 100 not divide by six");
   a_src_select: assert property (
      src_q[CCD_BIT_PRE_BYP] && src_q[CCD_BIT_SRC_SEL]
      |-> div_in == internal_oscillator_i)
      else $error("source select wrong");
   a_phase_hold: assert property (
      st_q == CCD_ST_RUN && in_rise && !align_i && hcnt_q < limit
      |=> $stable(lvl_q))
      else $error("phase ended early");
   a_delay_holds: assert property (
      st_q == CCD_ST_DELAY && !align_i |=> $stable(lvl_q))
      else $error("level moved during phase offset");

   c_align_delay: cover property (align_ok && ctrl_q.phase != 4'h0
      ##1 st_q == CCD_ST_DELAY);
   c_divider_toggle: cover property (st_q == CCD_ST_RUN && in_rise
      && hcnt_q >= limit);
   c_direct_osc: cover property (!pd && direct
      && src_q == CCD_SRC_OSC_DIRECT);
   c_power_down: cover property ($rose(pd));
endmodule
`default_nettype wire

// >>> ccd_channel_ctrl_tb.sv
// Self-checking bench for the group-three channel divider control block.
// Assumes ccd_pkg and ccd_channel_ctrl are compiled ahead of this file.
`timescale 1ns/10ps
`default_nettype none
module ccd_channel_ctrl_tb;
   import ccd_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clk = 1'b0; // 50 MHz
   logic rst_n = 1'b0; // Held low at start
   logic wr_en = 1'b0;
   logic [9:0] addr = 10'h000;
   logic [7:0] wdata = 8'h00;
   logic osc = 1'b0; // Period 4 cycles
   logic ext = 1'b0; // Period 6 cycles, so routes differ
   logic align = 1'b0;
   logic [7:0] rdata;
   logic out_a, out_b, out_c, pd, dcc;
   int n_fail = 0;
   int compares = 0;
   int ph = 0; // Cycle count, also the timeout
   logic [31:0] seed = 32'hd9d2f6fb;
   logic [7:0] mdl [1024]; // Register model
   int h, l, t0, t3;
   // Mapped offsets visited by the register passes
   logic [9:0] msk_list [5] = '{CCD_OFS_COUNTS, CCD_OFS_CTRL,
      CCD_OFS_ROUTE, CCD_OFS_PRESC, CCD_OFS_SRC};

   ccd_channel_ctrl i_dut (.ref_clk_i(clk), .rst_n_i(rst_n),
      .wr_en_i(wr_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
      .internal_oscillator_i(osc), .ext_clk_i(ext), .align_i(align),
      .group_output_a_o(out_a), .group_output_b_o(out_b),
      .group_output_c_o(out_c), .group_pd_o(pd),
      .duty_cycle_correction_en_o(dcc));

   // ------------------------------------------------------------
   // Clock, source levels, timeout
   // ------------------------------------------------------------
   always #10 clk = ~clk;

   // Sources move 1 ns after the edge, so the edge sees settled levels
   always @(posedge clk) begin
      #1;
      ph = ph + 1;
      osc = (ph % 4) >= 2;
      ext = (ph % 6) >= 3;
      if (ph > 20000) begin
         n_fail++;
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic complete_run();
      if (n_fail == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   // Implemented bits per offset; anything else reads zero
   function automatic logic [7:0] msk(input logic [9:0] a);
      case (a)
         CCD_OFS_COUNTS, CCD_OFS_CTRL: return 8'hff;
         CCD_OFS_ROUTE, CCD_OFS_PRESC: return 8'h07;
         CCD_OFS_SRC: return 8'h03;
         default: return 8'h00;
      endcase
   endfunction

   // One-cycle write strobe, model updated alongside
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1 wr_en = 1'b0;
      mdl[a] = d & msk(a);
   endtask

   // Read data lands one cycle after the address
   task automatic rd(input logic [9:0] a);
      @(posedge clk);
      #1 addr = a;
      @(posedge clk);
      #2 chk(rdata, mdl[a]);
   endtask

   // Mode 0 follows ext, 1 follows osc, 2 static low, 3 static high
   task automatic obs(input int m, input int n);
      logic s;
      repeat (2) @(posedge clk);
      repeat (n) begin
         @(posedge clk);
         s = (m == 0) ? ext : (m == 1) ? osc : m[0];
         #2;
         chk(out_a, s);
         chk(out_b, s);
         chk(out_c, s);
      end
   endtask

   // Cycles until output A reaches v; bounded so a stuck output ends
   task automatic wt(input logic v, output int c);
      c = 0;
      while (out_a !== v && c < 400) begin
         @(posedge clk);
         #2 c++;
      end
   endtask

   // High and low times of one full period after settling
   task automatic per(output int hi, output int lo);
      int k;
      repeat (40) @(posedge clk);
      // Off the edge, so the first look sees the settled output
      #2;
      wt(1'b0, k);
      wt(1'b1, k);
      wt(1'b0, hi);
      wt(1'b1, lo);
   endtask

   // Alignment at a fixed source phase; e is the level two edges on
   task automatic aln(input logic [7:0] c, input logic e, output int t);
      int k;
      wr(CCD_OFS_CTRL, c);
      wt(1'b1, k);
      wt(1'b0, k);
      do @(posedge clk); while (ph % 6 != 5);
      #1 align = 1'b1;
      @(posedge clk);
      #1 align = 1'b0;
      @(posedge clk);
      #2 chk(out_a, e);
      wt(!e, t);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      foreach (mdl[i]) mdl[i] = 8'h00;
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      // Reset state and register reads
      chk(dcc, 1'b1);
      chk(pd, 1'b0);
      foreach (msk_list[i]) rd(msk_list[i]);
      // Random data, back-to-back, unmapped offset refused
      foreach (msk_list[i]) begin
         seed = xs(seed);
         wr(msk_list[i], seed[7:0]);
         rd(msk_list[i]);
      end
      wr(10'h1ff, 8'hff);
      rd(10'h1ff);
      wr(CCD_OFS_ROUTE, 8'h00);
      wr(CCD_OFS_PRESC, 8'h00);
      wr(CCD_OFS_COUNTS, 8'h00);
      // Prescale ratios on ext, then one on osc, channel divider bypassed
      wr(CCD_OFS_SRC, 8'h00);
      wr(CCD_OFS_CTRL, 8'h80);
      for (int c = 0; c < 6; c++) begin
         wr(CCD_OFS_PRESC, c[7:0]);
         per(h, l);
         chk(h + l, 6 * ((c < 5) ? c + 2 : 2));
      end
      wr(CCD_OFS_SRC, 8'h02);
      wr(CCD_OFS_PRESC, 8'h01);
      per(h, l);
      chk(h + l, 12);
      // Channel divider counts on unprescaled ext
      wr(CCD_OFS_SRC, 8'h01);
      wr(CCD_OFS_CTRL, 8'h40);
      for (int i = 0; i < 3; i++) begin
         seed = xs(seed);
         wr(CCD_OFS_COUNTS, {2'h0, seed[5:4], 2'h0, seed[1:0]});
         per(h, l);
         chk(h, 6 * (seed[1:0] + 1));
         chk(l, 6 * (seed[5:4] + 1));
      end
      // Alignment: obeyed, ignored, phase delay
      wr(CCD_OFS_COUNTS, 8'h77);
      aln(8'h50, 1'b0, h);
      aln(8'h10, 1'b1, h);
      aln(8'h00, 1'b0, h);
      wr(CCD_OFS_COUNTS, 8'h00);
      aln(8'h10, 1'b1, t0);
      aln(8'h13, 1'b1, t3);
      chk(t3 - t0, 18);
      // Static force, only with ignore; bypass beats force
      wr(CCD_OFS_CTRL, 8'h70);
      obs(3, 30);
      wr(CCD_OFS_CTRL, 8'h60);
      obs(2, 30);
      wr(CCD_OFS_CTRL, 8'h30);
      per(h, l);
      chk(h + l, 12);
      wr(CCD_OFS_CTRL, 8'hf0);
      obs(0, 30);
      // Direct routing by source field
      wr(CCD_OFS_ROUTE, 8'h02);
      wr(CCD_OFS_SRC, 8'h02);
      obs(1, 30);
      wr(CCD_OFS_SRC, 8'h00);
      obs(0, 30);
      wr(CCD_OFS_CTRL, 8'h70);
      wr(CCD_OFS_SRC, 8'h01);
      obs(3, 30);
      // Field 01b with direct set and no ignore: divider keeps running
      wr(CCD_OFS_CTRL, 8'h30);
      per(h, l);
      chk(h + l, 12);
      // Power-down and duty correction
      wr(CCD_OFS_ROUTE, 8'h06);
      wr(CCD_OFS_SRC, 8'h02);
      obs(2, 20);
      chk(pd, 1'b1);
      wr(CCD_OFS_ROUTE, 8'h01);
      #2 chk(dcc, 1'b0);
      wr(CCD_OFS_ROUTE, 8'h00);
      #2 chk(dcc, 1'b1);
      chk(pd, 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
